// ==== verilog/strap_pins_regs.svh ====
// Purpose: Constants for the strap and status pin logic
// Assumes: 25 MHz clock
// Notes:   Times in ns, cycle counts derived here
`ifndef STRAP_PINS_REGS_SVH
`define STRAP_PINS_REGS_SVH

`define CLK_PERIOD_NS      40
`define STRAP_HOLD_NS      100
// Least time, rounded up to whole cycles
`define STRAP_HOLD_CYC     ((`STRAP_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Idle levels of the pins (pull-down on gang pin, pull-up on auto pin)
`define GANG_PIN_RST       1'h0
`define AUTO_PIN_RST       1'h1
`define GRST_N_RST         1'h0

// Strap field positions in the strap vector
`define STRAP_GANG_BIT     0
`define STRAP_AUTO_N_BIT   1

`endif

// ==== verilog/strap_pins_pkg.sv ====
// Purpose: Types for the strap and status pin logic
// Assumes: Nothing
// Notes:   Constants live in strap_pins_regs.svh
package strap_pins_pkg;

  typedef enum logic [1:0] {
    st_reset,
    st_hold,
    st_run
  } phase_type;

  typedef struct packed {
    logic auto_n;
    logic gang;
  } strap_type;

  typedef struct packed {
    logic value;
    logic oe;
  } pin_drive_type;

endpackage

// ==== verilog/sync_two_ff.sv ====
// Purpose: Two flip-flop synchroniser for pin levels
// Assumes: Levels only, no pulses
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
module sync_two_ff #(
  parameter int          WIDTH     = 1,
  parameter logic [WIDTH-1:0] RST_VALUE = '0
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q   <= RST_VALUE;
      sync_out <= RST_VALUE;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// ==== verilog/strap_and_status_pins.sv ====
// Purpose: Strap sampling and status drive of two shared hub pins
// Assumes: Status and config inputs come from logic on clk
// Notes:   Pins are tri-state, split into in, out and oe
`timescale 1ns/10ps
`include "strap_pins_regs.svh"

// Overview of operation
// - Sample gang pin at reset release: 0 individual, 1 ganged power.
// - In SMBus mode the sampled gang pin is slave address bit 2.
// - With status enabled, gang pin drives high-speed connection status.
// - Sample auto-charge pin at release: low enables automatic charge mode.
// - No charging downstream port behaviour on port 1 in automatic mode.
// - Sampled auto-charge level seeds the auto-charge configuration bit.
// - With status enabled, auto-charge pin drives high-speed suspend status.
// - Sampling follows release of the active-low global reset input.
module strap_and_status_pins #(
  parameter int PORTS = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             global_reset_n,
  // Gang / address / connection status pin
  input  wire logic             slave_addr_bit2_strap,
  output logic                  hs_link_up_out,
  output logic                  hs_link_up_oe,
  // Auto-charge / suspend status pin
  input  wire logic             auto_charge_strap_n,
  output logic                  out_a,
  output logic                  out_a_oe,
  // Hub state and configuration
  input  wire logic             status_output_enable,
  input  wire logic             smbus_select_n,
  input  wire logic             hs_connected,
  input  wire logic             hs_suspended,
  input  wire logic             hub_unconnected,
  input  wire logic [PORTS-1:0] charge_enable,
  input  wire logic [PORTS-1:0] cdp_request,
  input  wire logic             auto_cfg_wr,
  input  wire logic             auto_cfg_wr_data,
  // Decoded results
  output logic                  ganged_power,
  output logic                  slave_addr_bit2,
  output logic                  auto_charge_cfg_n,
  output logic                  auto_mode_active,
  output logic [PORTS-1:0]      cdp_enable,
  output logic                  strap_conflict,
  output logic                  straps_valid
);

  localparam int HOLD_CYC = `STRAP_HOLD_CYC;
  localparam int CW       = $clog2(HOLD_CYC + 1);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [2:0] pins_raw;
  logic [2:0] pins_sync;

  assign pins_raw = {global_reset_n, auto_charge_strap_n,
                     slave_addr_bit2_strap};

  // Reset value matches the board pulls, so no false strap
  sync_two_ff #(
    .WIDTH     (3),
    .RST_VALUE ({`GRST_N_RST, `AUTO_PIN_RST, `GANG_PIN_RST})
  ) i_sync_two_ff (
    .clk      (clk),
    .rst      (rst),
    .async_in (pins_raw),
    .sync_out (pins_sync)
  );

  wire grst_n_s = pins_sync[2];
  wire auto_s   = pins_sync[`STRAP_AUTO_N_BIT];
  wire gang_s   = pins_sync[`STRAP_GANG_BIT];

  // ************************************************************
  // Phase control
  // ************************************************************
  strap_pins_pkg::phase_type phase_q;
  strap_pins_pkg::phase_type phase_d;
  logic [CW-1:0]             hold_cnt_q;
  logic [CW-1:0]             hold_cnt_d;
  strap_pins_pkg::strap_type strap_q;
  strap_pins_pkg::strap_type strap_d;
  logic                      auto_cfg_q;
  logic                      auto_cfg_d;

  wire release_now = (phase_q == strap_pins_pkg::st_reset) && grst_n_s;
  wire hold_done   = (hold_cnt_q == CW'(HOLD_CYC));

  always_comb begin
    phase_d    = phase_q;
    hold_cnt_d = hold_cnt_q;
    case (phase_q)
      strap_pins_pkg::st_reset: begin
        hold_cnt_d = '0;
        if (grst_n_s) begin
          phase_d = strap_pins_pkg::st_hold;
        end
      end
      strap_pins_pkg::st_hold: begin
        // Keep pins released through the strap hold time
        hold_cnt_d = hold_cnt_q + CW'(1);
        if (hold_done) begin
          phase_d = strap_pins_pkg::st_run;
        end
      end
      strap_pins_pkg::st_run: begin
        hold_cnt_d = hold_cnt_q;
      end
      default: begin
        phase_d    = strap_pins_pkg::st_reset;
        hold_cnt_d = '0;
      end
    endcase
    // Synced reset low wins over every phase
    if (!grst_n_s) begin
      phase_d    = strap_pins_pkg::st_reset;
      hold_cnt_d = '0;
    end
  end

  // ************************************************************
  // Run phase and configuration write acceptance
  // ************************************************************
  wire in_run       = (phase_q == strap_pins_pkg::st_run);
  wire cfg_write_ok = auto_cfg_wr && in_run;

  // ************************************************************
  // Strap latch and configuration bit
  // ************************************************************
  always_comb begin
    strap_d = strap_q;
    if (release_now) begin
      strap_d.gang   = gang_s;
      strap_d.auto_n = auto_s;
    end
  end

  always_comb begin
    auto_cfg_d = auto_cfg_q;
    if (release_now) begin
      auto_cfg_d = auto_s;
    end else if (cfg_write_ok) begin
      auto_cfg_d = auto_cfg_wr_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q    <= strap_pins_pkg::st_reset;
      hold_cnt_q <= '0;
      strap_q    <= '{auto_n: `AUTO_PIN_RST, gang: `GANG_PIN_RST};
      auto_cfg_q <= `AUTO_PIN_RST;
    end else begin
      phase_q    <= phase_d;
      hold_cnt_q <= hold_cnt_d;
      strap_q    <= strap_d;
      auto_cfg_q <= auto_cfg_d;
    end
  end

  // ************************************************************
  // Status drive of the pins
  // ************************************************************
  strap_pins_pkg::pin_drive_type gang_drv_q;
  strap_pins_pkg::pin_drive_type gang_drv_d;
  strap_pins_pkg::pin_drive_type auto_drv_q;
  strap_pins_pkg::pin_drive_type auto_drv_d;

  // Let go of the pins at the clock edge after the synced reset falls
  wire drive_ok   = in_run && grst_n_s && status_output_enable;
  wire gang_level = drive_ok && hs_connected;
  wire susp_level = drive_ok && hs_suspended;

  assign gang_drv_d = '{value: gang_level,
                        oe:    drive_ok};
  assign auto_drv_d = '{value: susp_level,
                        oe:    drive_ok};

  // Registered so the pins never glitch from decode
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gang_drv_q <= '{value: 1'h0, oe: 1'h0};
      auto_drv_q <= '{value: 1'h0, oe: 1'h0};
    end else begin
      gang_drv_q <= gang_drv_d;
      auto_drv_q <= auto_drv_d;
    end
  end

  assign hs_link_up_out = gang_drv_q.value;
  assign hs_link_up_oe  = gang_drv_q.oe;
  assign out_a          = auto_drv_q.value;
  assign out_a_oe       = auto_drv_q.oe;

  // ************************************************************
  // Decoded configuration
  // ************************************************************
  wire valid_w = (phase_q != strap_pins_pkg::st_reset);
  wire auto_w  = valid_w && !auto_cfg_q && hub_unconnected;

  logic [PORTS-1:0] cdp_mask;

  always_comb begin
    cdp_mask    = '1;
    cdp_mask[0] = !auto_w;
  end

  assign straps_valid      = valid_w;
  assign ganged_power      = strap_q.gang;
  assign slave_addr_bit2   = !smbus_select_n && strap_q.gang;
  assign auto_charge_cfg_n = auto_cfg_q;
  assign auto_mode_active  = auto_w;
  assign cdp_enable        = cdp_request & charge_enable & cdp_mask;
  // Flags a board that gangs power while charging is in use
  wire any_charge = |charge_enable;
  assign strap_conflict    = valid_w && strap_q.gang && any_charge;

endmodule

// ==== sim/strap_board.sv ====
// Purpose: Board strap resistors on the two pins
// Assumes: Strap resistor beats internal pulls
// Notes:   Pin shows device level while driven
`timescale 1ns/10ps
module strap_board (
  // Device drive
  input  wire logic gang_oe,
  input  wire logic gang_val,
  input  wire logic auto_oe,
  input  wire logic auto_val,
  // Strap choice
  input  wire logic gang_strap,
  input  wire logic auto_strap_n,
  // Pin levels
  output logic      gang_pin,
  output logic      auto_pin
);
  assign gang_pin = gang_oe ? gang_val : gang_strap;
  assign auto_pin = auto_oe ? auto_val : auto_strap_n;
endmodule

// ==== sim/strap_pins_assertions.sv ====
// Purpose: Checks on strap and status pins
// Assumes: Single clock, rst async
// Notes:   Bound into the design below
`timescale 1ns/10ps
module strap_pins_assertions #(
  parameter int PORTS = 4
) (
  // Clock and resets
  input wire logic             clk,
  input wire logic             rst,
  input wire logic             global_reset_n,
  // Pins
  input wire logic             slave_addr_bit2_strap,
  input wire logic             auto_charge_strap_n,
  input wire logic             hs_link_up_out,
  input wire logic             hs_link_up_oe,
  input wire logic             out_a,
  input wire logic             out_a_oe,
  // Hub state
  input wire logic             status_output_enable,
  input wire logic             smbus_select_n,
  input wire logic             hs_connected,
  input wire logic             hs_suspended,
  input wire logic             hub_unconnected,
  input wire logic [PORTS-1:0] charge_enable,
  // Results
  input wire logic             ganged_power,
  input wire logic             slave_addr_bit2,
  input wire logic             auto_charge_cfg_n,
  input wire logic             auto_mode_active,
  input wire logic [PORTS-1:0] cdp_enable,
  input wire logic             strap_conflict,
  input wire logic             straps_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence release_seen;
    $rose(global_reset_n) ##1 global_reset_n [*4];
  endsequence
  chk_gang_latch: assert property (
    release_seen |-> straps_valid && ganged_power ==
      $past(slave_addr_bit2_strap, 5)) else $error("gang latch");
  chk_cfg_latch: assert property (
    release_seen |-> auto_charge_cfg_n == $past(auto_charge_strap_n, 5))
    else $error("auto latch");
  chk_straps_held: assert property (
    straps_valid && $past(straps_valid) |-> $stable(ganged_power))
    else $error("gang moved");
  chk_addr_bit: assert property (
    slave_addr_bit2 == (!smbus_select_n && ganged_power))
    else $error("addr bit");
  chk_link_status: assert property (
    hs_link_up_oe |-> hs_link_up_out == $past(hs_connected)
      && $past(status_output_enable)) else $error("link pin");
  chk_susp_status: assert property (
    out_a_oe |-> out_a == $past(hs_suspended)
      && $past(status_output_enable)) else $error("suspend pin");
  chk_pins_quiet: assert property (
    !global_reset_n [*5] |-> !hs_link_up_oe && !out_a_oe)
    else $error("pin driven in reset");
  chk_auto_mode: assert property (
    auto_mode_active == (straps_valid && !auto_charge_cfg_n
      && hub_unconnected)) else $error("auto mode");
  chk_port_cdp: assert property (
    auto_mode_active |-> !cdp_enable[0]) else $error("port 1 cdp");
  chk_gang_conflict: assert property (
    strap_conflict == (straps_valid && ganged_power && |charge_enable))
    else $error("conflict flag");
endmodule
bind strap_and_status_pins strap_pins_assertions #(.PORTS(PORTS)) i_chk (.*);

// ==== sim/test_strap_and_status_pins.sv ====
// Purpose: Self-checking bench for strap and status pins
// Assumes: Pins stay put around global reset release
// Notes:   Model state kept in bench variables
`timescale 1ns/10ps
module test_strap_and_status_pins;
  logic clk = 0, rst = 1, grst_n = 0, st_en = 0, smb_n = 1, hs_c = 0;
  logic hs_s = 0, unc = 0, wr = 0, wr_d = 0, gs = 0, as_n = 1;
  logic [3:0] ce = 0, req = 0, cdp;
  logic gpin, apin, lu, lu_oe, aout, a_oe, gp, sa2, cfg_n, am, conf, sv;
  logic g_exp, c_exp, pc, ps, pe, pw, pwd;
  logic [4:0] in_q[$];
  int num_errors = 0, checks_done = 0;
  int unsigned seed = 45;
  strap_and_status_pins #(.PORTS(4)) i_strap_and_status_pins (
    .clk(clk), .rst(rst), .global_reset_n(grst_n),
    .slave_addr_bit2_strap(gpin), .hs_link_up_out(lu),
    .hs_link_up_oe(lu_oe), .auto_charge_strap_n(apin), .out_a(aout),
    .out_a_oe(a_oe), .status_output_enable(st_en),
    .smbus_select_n(smb_n), .hs_connected(hs_c), .hs_suspended(hs_s),
    .hub_unconnected(unc), .charge_enable(ce), .cdp_request(req),
    .auto_cfg_wr(wr), .auto_cfg_wr_data(wr_d), .ganged_power(gp),
    .slave_addr_bit2(sa2), .auto_charge_cfg_n(cfg_n),
    .auto_mode_active(am), .cdp_enable(cdp), .strap_conflict(conf),
    .straps_valid(sv));
  strap_board i_strap_board (.gang_oe(lu_oe), .gang_val(lu),
    .auto_oe(a_oe), .auto_val(aout), .gang_strap(gs),
    .auto_strap_n(as_n), .gang_pin(gpin), .auto_pin(apin));
  initial forever #20 clk = ~clk;
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(string name, logic [3:0] seen, logic [3:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic restrap(logic g, logic a);
    @(posedge clk);
    grst_n <= 0;
    wr <= 0;
    gs <= g;
    as_n <= a;
    repeat (8) @(posedge clk);
    @(negedge clk);
    check("oe_in_reset", {a_oe, lu_oe}, 0);
    check("valid_in_reset", sv, 0);
    @(posedge clk);
    grst_n <= 1;
    g_exp = g;
    c_exp = a;
    // Two sync stages, then the latch edge
    repeat (2) @(posedge clk);
    @(negedge clk);
    check("valid_early", sv, 0);
    @(negedge clk);
    check("straps_valid", sv, 1);
    check("gang_latched", gp, g_exp);
    check("cfg_latched", cfg_n, c_exp);
    repeat (3) @(posedge clk);
    // Straps swapped after latch
    gs <= ~g;
    as_n <= ~a;
    repeat (8) @(posedge clk);
    @(negedge clk);
    check("ganged_power", gp, g_exp);
    check("cfg_n", cfg_n, c_exp);
  endtask
  task automatic run_random(int cycles);
    logic [31:0] r;
    repeat (cycles) begin
      @(posedge clk);
      r = xs();
      // Inputs that the design takes at this edge
      in_q.push_back({st_en, hs_c, hs_s, wr, wr_d});
      {st_en, hs_c, hs_s, unc, smb_n} <= r[4:0];
      ce <= r[8:5];
      req <= r[12:9];
      wr <= r[13] & r[14];
      wr_d <= r[15];
      @(negedge clk);
      {pe, pc, ps, pw, pwd} = in_q.pop_front();
      if (pw) c_exp = pwd;
      check("link_oe", lu_oe, pe);
      check("link_out", lu, pc & pe);
      check("susp_oe", a_oe, pe);
      check("susp_out", aout, ps & pe);
      check("cfg_n", cfg_n, c_exp);
      check("addr_bit2", sa2, !smb_n && g_exp);
      check("auto_mode", am, !c_exp && unc);
      check("cdp", cdp, req & ce & ~{3'h0, !c_exp && unc});
      check("conflict", conf, g_exp && ce != 0);
    end
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 0;
    for (int i = 0; i < 4; i++) begin
      restrap(i[0], i[1]);
      run_random(200);
      $display("strap test %0d done", i);
    end
    wrap_up();
  end
  initial begin
    #(40 * 3000);
    num_errors++;
    wrap_up();
  end
endmodule
